// *** spo_defines.vh ***
`ifndef SPO_DEFINES_VH
`define SPO_DEFINES_VH

// register offsets
`define SPO_A_MODE 4'h0
`define SPO_A_SPEED 4'h1
`define SPO_A_MAXF 4'h2
`define SPO_A_DECEL 4'h3
`define SPO_A_ZONE 4'h4
`define SPO_A_DETECT 4'h5
`define SPO_A_HOLD 4'h6
`define SPO_A_STAT 4'h7
`define SPO_A_ISTAT 4'h8
`define SPO_A_IEN 4'h9
`define SPO_A_ICLR 4'ha

// reset values
`define SPO_R_MODE 16'h0000
`define SPO_R_SPEED 16'h03e8
`define SPO_R_MAXF 16'h1388
`define SPO_R_DECEL 16'h001e
`define SPO_R_ZONE 16'h000a
`define SPO_R_DETECT 16'h0064
`define SPO_R_HOLD 16'h00c8

// mode word fields
`define SPO_B_EN 0
`define SPO_B_REFSRC 1
`define SPO_B_SEARCH 2
`define SPO_B_CALEN 3
`define SPO_B_NEAR 4
`define SPO_B_REV 5
`define SPO_B_PULSE 6
`define SPO_B_CALRT 7
`define SPO_B_LOCK 8
`define SPO_B_DPULSE 9
`define SPO_B_ZSRC 10

// interrupt bits
`define SPO_I_DONE 0
`define SPO_I_REF 1
`define SPO_I_ABORT 2

// states
`define SPO_S_IDLE 3'h0
`define SPO_S_SEARCH 3'h1
`define SPO_S_DECEL 3'h2
`define SPO_S_SETTLE 3'h3
`define SPO_S_DONE 3'h4

// timing
`define SPO_CLK_NS 20
`define SPO_TICK_NS 100000
`define SPO_MS_TICKS 10
`define SPO_DECEL_MAX 16'h03e8

`endif

// *** spo_orient.v ***
`timescale 1ns/10ps
`include "spo_defines.vh"

module spo_orient
#(
	parameter TICK_CYC = `SPO_TICK_NS / `SPO_CLK_NS
)
(
	// clock, reset, enable
	input wire core_clk,
	input wire nrst,
	input wire clk_en,
	// register port
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	// drive state and commands
	input wire closed_loop_vector,
	input wire run_cmd,
	input wire zero_cmd,
	// encoder index and terminals
	input wire motor_index,
	input wire spindle_index,
	input wire digital_input_two,
	input wire digital_input_three,
	input wire digital_input_four,
	input wire [2:0] ref_assign,
	// feedback from the position loop
	input wire [15:0] pos_err,
	input wire near_is_rev,
	// to the speed/position loop
	output reg [15:0] speed_ref,
	output reg dir_rev,
	output reg pos_mode,
	output reg pos_lock,
	output reg zero_pos,
	output reg orient_done,
	output reg irq
);

	reg [15:0] mode_r;
	reg [15:0] speed_r;
	reg [15:0] maxf_r;
	reg [15:0] decel_r;
	reg [15:0] zone_r;
	reg [15:0] detect_r;
	reg [15:0] hold_r;
	reg [2:0] istat_r;
	reg [2:0] ien_r;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [4:0] sync1_r;
	reg [4:0] sync2_r;
	reg [4:0] prev_r;
	reg zcmd_prev_r;
	reg found_r;
	reg cal_done_r;
	reg [12:0] tick_cnt_r;
	reg tick_r;
	reg [20:0] acc_r;
	reg [15:0] det_cnt_r;
	reg [19:0] hold_cnt_r;
	reg done_prev_r;

	// configuration fields
	wire m_en = mode_r[`SPO_B_EN];
	wire m_pulse = mode_r[`SPO_B_PULSE];
	wire m_lock = mode_r[`SPO_B_LOCK];
	wire m_dpulse = mode_r[`SPO_B_DPULSE];

	// only closed-loop vector mode may orient at all
	wire allowed = m_en & closed_loop_vector;

	// synchronised edges; first stage is read only by the second
	wire [4:0] rise = sync2_r & ~prev_r;
	wire idx_edge = mode_r[`SPO_B_ZSRC] ? rise[1] : rise[0];
	wire sw_edge = |(rise[4:2] & ref_assign);
	wire ref_edge = mode_r[`SPO_B_REFSRC] ? sw_edge : idx_edge;

	// command decode: level needs run, pulse takes an edge without run
	// zero_cmd arrives synchronous, so its edge needs no extra flops
	wire zc_rise = zero_cmd & ~zcmd_prev_r;
	wire lvl_req = zero_cmd & run_cmd;
	wire start = m_pulse ? (zc_rise & ~run_cmd) : lvl_req;
	wire run_abort = m_pulse & run_cmd;
	wire lvl_drop = ~m_pulse & ~lvl_req;

	// search speed never exceeds the max output frequency
	wire [15:0] search_spd = (speed_r > maxf_r) ? maxf_r : speed_r;

	// ramp denominator: decel time in 0.1 s is 1000 ticks of 0.1 ms each
	// limitation: one step per tick at most; short times ramp slower
	wire [25:0] denom = {10'h000, decel_r} * 26'h00003e8;
	wire [20:0] acc_sum = acc_r + {5'h00, maxf_r};
	wire step_dn = tick_r & ({5'h00, acc_sum} >= denom);

	// an error equal to the zone counts as outside
	wire in_zone = pos_err < zone_r;
	wire settled = in_zone & (det_cnt_r > detect_r);
	wire [19:0] hold_ticks = hold_r * 20'h0000a;
	wire hold_live = hold_cnt_r != 20'h00000;
	// one cycle at completion entry; reloads the hold counter and
	// still gives a visible pulse when the hold time is zero
	wire done_entry = (state_r == `SPO_S_DONE) & ~done_prev_r;

	// reference needed again unless search-once already found it
	wire need_search = mode_r[`SPO_B_SEARCH] | ~found_r;

	// calibration needs the function live; bit 7 picks first or every edge
	wire cal_hit = allowed & ref_edge & mode_r[`SPO_B_CALEN] &
		(mode_r[`SPO_B_CALRT] | ~cal_done_r);

	// sticky event sources and the write-one-to-clear mask
	wire evt_abort = (state_r != `SPO_S_IDLE) &
		(state_nxt == `SPO_S_IDLE);
	wire evt_ref = (state_r == `SPO_S_SEARCH) & ref_edge;
	wire [2:0] evt_set = {evt_abort, evt_ref, done_entry};
	wire [2:0] clr_mask = (reg_wr & (reg_addr == `SPO_A_ICLR)) ?
		reg_wdata[2:0] : 3'h0;

	// next state
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			`SPO_S_IDLE:
				if (allowed & start)
					state_nxt = need_search ? `SPO_S_SEARCH : `SPO_S_DECEL;
			`SPO_S_SEARCH:
				// the reference edge ends the constant-speed search
				if (ref_edge)
					state_nxt = `SPO_S_DECEL;
			`SPO_S_DECEL:
				if (speed_ref == 16'h0000)
					state_nxt = `SPO_S_SETTLE;
			`SPO_S_SETTLE:
				if (settled)
					state_nxt = `SPO_S_DONE;
			`SPO_S_DONE:
				// a pulse may restart from done without passing idle
				if (m_pulse & zc_rise & ~run_cmd)
					state_nxt = need_search ? `SPO_S_SEARCH : `SPO_S_DECEL;
			default:
				state_nxt = `SPO_S_IDLE;
		endcase
		// aborts override every active state
		if (state_r != `SPO_S_IDLE)
		begin
			if (~allowed | run_abort)
				state_nxt = `SPO_S_IDLE;
			// withdrawn level command: bit 8 may keep done locked
			else if (lvl_drop & ~(state_r == `SPO_S_DONE & m_lock))
				state_nxt = `SPO_S_IDLE;
		end
	end

	// input synchronisers and edge history
	// two flops per pin; the edge history reads only the second
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			sync1_r <= 5'h00;
			sync2_r <= 5'h00;
			prev_r <= 5'h00;
			zcmd_prev_r <= 1'b0;
		end
		else if (clk_en)
		begin
			sync1_r <= {digital_input_four, digital_input_three,
				digital_input_two, spindle_index, motor_index};
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
			zcmd_prev_r <= zero_cmd;
		end
	end

	// 0.1 ms time base shared by ramp, detect and hold
	// one shared divider keeps each timer counter narrow
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			tick_cnt_r <= 13'h0000;
			tick_r <= 1'b0;
		end
		else if (clk_en)
		begin
			tick_r <= 1'b0;
			if (tick_cnt_r == TICK_CYC[12:0] - 13'h0001)
			begin
				tick_cnt_r <= 13'h0000;
				tick_r <= 1'b1;
			end
			else
				tick_cnt_r <= tick_cnt_r + 13'h0001;
		end
	end

	// registers written by software
	// bits 15:11 of the mode word are reserved and read back as zero
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			mode_r <= `SPO_R_MODE;
			speed_r <= `SPO_R_SPEED;
			maxf_r <= `SPO_R_MAXF;
			decel_r <= `SPO_R_DECEL;
			zone_r <= `SPO_R_ZONE;
			detect_r <= `SPO_R_DETECT;
			hold_r <= `SPO_R_HOLD;
			ien_r <= 3'h0;
		end
		else if (clk_en & reg_wr)
		begin
			case (reg_addr)
				`SPO_A_MODE: mode_r <= {5'h00, reg_wdata[10:0]};
				`SPO_A_SPEED: speed_r <= reg_wdata;
				`SPO_A_MAXF: maxf_r <= reg_wdata;
				// zero would make every tick a ramp step; above the longest
				// time the accumulator could wrap and stop the ramp
				`SPO_A_DECEL: decel_r <= (reg_wdata == 16'h0000) ?
					16'h0001 : (reg_wdata > `SPO_DECEL_MAX) ?
					`SPO_DECEL_MAX : reg_wdata;
				`SPO_A_ZONE: zone_r <= reg_wdata;
				`SPO_A_DETECT: detect_r <= reg_wdata;
				`SPO_A_HOLD: hold_r <= reg_wdata;
				`SPO_A_IEN: ien_r <= reg_wdata[2:0];
				default: ien_r <= ien_r;
			endcase
		end
	end

	// sequencer, ramp and loop commands
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			state_r <= `SPO_S_IDLE;
			speed_ref <= 16'h0000;
			dir_rev <= 1'b0;
			pos_mode <= 1'b0;
			pos_lock <= 1'b0;
			zero_pos <= 1'b0;
			found_r <= 1'b0;
			cal_done_r <= 1'b0;
			acc_r <= 21'h000000;
			det_cnt_r <= 16'h0000;
		end
		else if (clk_en)
		begin
			state_r <= state_nxt;
			zero_pos <= 1'b0;
			// direction policy follows the mode word live
			dir_rev <= mode_r[`SPO_B_NEAR] ? near_is_rev :
				mode_r[`SPO_B_REV];
			// position control from the start of deceleration to the end of done
			pos_mode <= (state_nxt == `SPO_S_DECEL) |
				(state_nxt == `SPO_S_SETTLE) |
				(state_nxt == `SPO_S_DONE);
			pos_lock <= (state_nxt == `SPO_S_DONE);
			// found stays set until reset; search-once relies on it
			if (evt_ref)
				found_r <= 1'b1;
			// calibration zeroes the loop position counter
			if (cal_hit)
			begin
				zero_pos <= 1'b1;
				cal_done_r <= 1'b1;
			end
			case (state_nxt)
				// the accumulator restarts with every search
				`SPO_S_SEARCH:
				begin
					speed_ref <= search_spd;
					acc_r <= 21'h000000;
				end
				`SPO_S_DECEL:
					if (step_dn & speed_ref != 16'h0000)
					begin
						speed_ref <= speed_ref - 16'h0001;
						// the remainder carries over to keep the slope
						acc_r <= acc_sum - denom[20:0];
					end
					else if (tick_r)
						acc_r <= acc_sum;
				// idle or holding: no speed setpoint from here
				default:
				begin
					speed_ref <= 16'h0000;
					acc_r <= 21'h000000;
				end
			endcase
			// error must stay inside the zone continuously
			if (state_r != `SPO_S_SETTLE | ~in_zone)
				det_cnt_r <= 16'h0000;
			else if (tick_r & det_cnt_r != 16'hffff)
				det_cnt_r <= det_cnt_r + 16'h0001;
		end
	end

	// completion output; pulse mode drops after the hold time
	// the hold counter runs on the shared 0.1 ms tick
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			orient_done <= 1'b0;
			hold_cnt_r <= 20'h00000;
			done_prev_r <= 1'b0;
		end
		else if (clk_en)
		begin
			done_prev_r <= (state_r == `SPO_S_DONE);
			if (done_entry)
				hold_cnt_r <= hold_ticks;
			else if (tick_r & hold_live)
				hold_cnt_r <= hold_cnt_r - 20'h00001;
			// level mode holds while locked and at least the hold time
			// the pulse rises at entry too, so both modes share one latency
			if (m_dpulse)
				orient_done <= hold_live | done_entry;
			else
				orient_done <= (state_r == `SPO_S_DONE) |
					hold_live;
		end
	end

	// sticky events; a set in the clear cycle survives
	always @(posedge core_clk)
	begin
		if (!nrst)
		begin
			istat_r <= 3'h0;
			irq <= 1'b0;
		end
		else if (clk_en)
		begin
			istat_r <= (istat_r & ~clr_mask) | evt_set;
			// irq trails the status bits by one cycle
			irq <= |(istat_r & ien_r);
		end
	end

	// read port, data in the cycle after the strobe
	// reads have no side effects, so polling status is harmless
	always @(posedge core_clk)
	begin
		if (!nrst)
			reg_rdata <= 16'h0000;
		else if (clk_en)
		begin
			reg_rdata <= 16'h0000;
			if (reg_rd)
				case (reg_addr)
					`SPO_A_MODE: reg_rdata <= mode_r;
					`SPO_A_SPEED: reg_rdata <= speed_r;
					`SPO_A_MAXF: reg_rdata <= maxf_r;
					`SPO_A_DECEL: reg_rdata <= decel_r;
					`SPO_A_ZONE: reg_rdata <= zone_r;
					`SPO_A_DETECT: reg_rdata <= detect_r;
					`SPO_A_HOLD: reg_rdata <= hold_r;
					// status: done, calibrated, found, state
					`SPO_A_STAT: reg_rdata <= {10'h000, orient_done,
						cal_done_r, found_r, state_r};
					`SPO_A_ISTAT: reg_rdata <= {13'h0000, istat_r};
					`SPO_A_IEN: reg_rdata <= {13'h0000, ien_r};
					default: reg_rdata <= 16'h0000;
				endcase
		end
	end

endmodule

// *** spo_orient_asserts.sv ***
`timescale 1ns/10ps
`include "spo_defines.vh"
// port checks for spo_orient
module spo_orient_chk (
	// clock and reset
	input wire core_clk,
	input wire nrst,
	// register port
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	// drive state and commands
	input wire closed_loop_vector,
	input wire run_cmd,
	input wire zero_cmd,
	// loop side
	input wire [15:0] speed_ref,
	input wire pos_mode,
	input wire pos_lock,
	input wire zero_pos,
	input wire orient_done
);
	reg [15:0] mode_r;
	default clocking dck @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// shadow of the mode word; clk_en is held high by the bench
	always @(posedge core_clk)
		if (!nrst)
			mode_r <= 16'h0000;
		else if (reg_wr && reg_addr == `SPO_A_MODE)
			mode_r <= reg_wdata;
	sequence vec_gone;
		!closed_loop_vector ##1 !closed_loop_vector;
	endsequence
	sequence lock_rise;
		!pos_lock ##1 pos_lock;
	endsequence
	rd_idle_a: assert property (
		!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata not idle");
	off_idle_a: assert property (
		vec_gone |-> !pos_mode && !pos_lock) else $error("runs without vector");
	done_rise_a: assert property (
		lock_rise |=> orient_done) else $error("done late");
	done_level_a: assert property (
		!mode_r[9] && pos_lock && $past(pos_lock) |-> orient_done)
		else $error("done level dropped");
	pulse_abort_a: assert property (
		mode_r[6] && run_cmd |=> !pos_mode) else $error("run kept position");
	lvl_drop_a: assert property (
		!mode_r[6] && !mode_r[8] && !zero_cmd |=> !pos_mode)
		else $error("level drop kept position");
	lock_hold_a: assert property (
		mode_r[0] && !mode_r[6] && mode_r[8] && pos_lock && closed_loop_vector
		|=> pos_lock) else $error("lock lost");
	ramp_step_a: assert property (
		pos_mode && !pos_lock && $past(pos_mode) && $past(pos_mode, 2)
		|-> speed_ref <= $past(speed_ref) && $past(speed_ref) - speed_ref < 2)
		else $error("ramp step wrong");
	zero_pulse_a: assert property (
		zero_pos |-> mode_r[3] ##1 !zero_pos) else $error("zero pulse wrong");
endmodule

bind spo_orient spo_orient_chk spo_orient_chk_inst (.core_clk, .nrst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.closed_loop_vector, .run_cmd, .zero_cmd, .speed_ref, .pos_mode,
	.pos_lock, .zero_pos, .orient_done);

// *** spo_ref_src.sv ***
`timescale 1ns/10ps
// far side: index pulses and reference switches, after a delay
module spo_ref_src (
	// clock
	input wire core_clk,
	// request from the bench
	input wire [4:0] fire,
	input wire [7:0] gap,
	// lines: four, three, two, spindle, motor
	output logic [4:0] pins
);
	logic [4:0] sel;
	int n;
	initial
	begin
		pins = 5'h00;
		sel = 5'h00;
		n = -1;
	end
	// three cycles high, long enough to pass the input sync
	always @(posedge core_clk)
		if (fire != 5'h00)
		begin
			sel <= fire;
			n <= gap + 4;
		end
		else if (n >= 0)
		begin
			n <= n - 1;
			pins <= (n > 0 && n < 4) ? sel : 5'h00;
		end
endmodule

// *** spindle_orientation_control_bench.sv ***
`timescale 1ns/10ps
`include "spo_defines.vh"
module spindle_orientation_control_bench;
	logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, clv = 1;
	logic run_cmd = 0, zero_cmd = 0, near = 0;
	logic [3:0] reg_addr = 0;
	logic [4:0] fire = 0;
	logic [7:0] gap = 0;
	logic [15:0] reg_wdata = 0, pos_err = 0, sp, mf;
	wire [15:0] reg_rdata, speed_ref;
	wire [4:0] pins;
	wire dir_rev, pos_mode, pos_lock, zero_pos, orient_done, irq;
	wire [3:0] st = {orient_done, pos_lock, pos_mode, speed_ref != 16'h0000};
	int bad_count = 0, samples_checked = 0, n, zp_n = 0;
	logic [15:0] modes [4] = '{16'h0109, 16'h0001, 16'h0667, 16'h0495};
	logic [4:0] fires [4] = '{5'h01, 5'h00, 5'h08, 5'h02};
	logic [15:0] dflt [7] = '{`SPO_R_MODE, `SPO_R_SPEED, `SPO_R_MAXF,
		`SPO_R_DECEL, `SPO_R_ZONE, `SPO_R_DETECT, `SPO_R_HOLD};
	always #10 core_clk = ~core_clk;
	// calibration pulses seen on the loop side
	always @(posedge core_clk)
		if (zero_pos)
			zp_n++;
	// short tick keeps ramps to about two thousand cycles and hold times to about twenty
	spo_orient #(.TICK_CYC(2)) spo_orient_inst (.core_clk, .nrst,
		.clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.closed_loop_vector(clv), .run_cmd, .zero_cmd,
		.motor_index(pins[0]), .spindle_index(pins[1]),
		.digital_input_two(pins[2]), .digital_input_three(pins[3]),
		.digital_input_four(pins[4]), .ref_assign(3'h2), .pos_err,
		.near_is_rev(near), .speed_ref, .dir_rev, .pos_mode, .pos_lock,
		.zero_pos, .orient_done, .irq);
	spo_ref_src spo_ref_src_inst (.core_clk, .fire, .gap, .pins);
	task chk(input string s, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e, m);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 chk("reg_rdata", e, reg_rdata & m);
	endtask
	task irqchk(input logic e);
		repeat (2) @(posedge core_clk);
		#1 chk("irq", e, irq);
	endtask
	// bounded wait for one status line to reach a level
	task wt(input int k, input logic v);
		n = 0;
		do
		begin
			@(posedge core_clk);
			#1 n++;
			if (n > 20000)
			begin
				chk("wait", 0, 1);
				results;
			end
		end
		while (st[k] !== v);
	endtask
	task run(input logic [15:0] m, input logic [4:0] f);
		sp = 16'd900 + 16'($urandom % 400);
		mf = 16'd1000 + 16'($urandom % 200);
		wr(`SPO_A_SPEED, sp);
		wr(`SPO_A_MAXF, mf);
		wr(`SPO_A_MODE, m);
		@(posedge core_clk);
		near <= 1'($urandom);
		gap <= 8'($urandom % 40);
		pos_err <= 16'($urandom % 10);
		zero_cmd <= 1;
		run_cmd <= !m[6];
		@(posedge core_clk);
		zero_cmd <= !m[6];
		if (f != 0)
		begin
			wt(0, 1);
			chk("speed_ref", sp < mf ? sp : mf, speed_ref);
			chk("pos_mode", 0, pos_mode);
			@(posedge core_clk);
			fire <= f;
			@(posedge core_clk);
			fire <= 0;
		end
		wt(1, 1);
		if (f == 0)
			chk("skip", 1, n < 4);
		wt(2, 1);
		chk("dir_rev", m[4] ? near : m[5], dir_rev);
		wt(3, 1);
		chk("done delay", 1, 16'(n));
		if (m[9])
		begin
			wt(3, 0);
			chk("hold", 1, n > 18 && n < 22);
			chk("pos_lock", 1, pos_lock);
		end
		@(posedge core_clk);
		run_cmd <= m[6];
		zero_cmd <= 0;
		repeat (2) @(posedge core_clk);
		#1 chk("pos_lock", !m[6] && m[8], pos_lock);
		@(posedge core_clk);
		clv <= 0;
		repeat (2) @(posedge core_clk);
		clv <= 1;
		run_cmd <= 0;
		#1 chk("pos_mode", 0, pos_mode);
	endtask
	initial
	begin
		void'($urandom(32'h862b));
		repeat (6) @(posedge core_clk);
		nrst <= 1;
		for (int i = 0; i < 7; i++)
			rd(4'(i), dflt[i], 16'hffff);
		rd(4'hb, 0, 16'hffff);
		wr(`SPO_A_MODE, 16'hffff);
		rd(`SPO_A_MODE, 16'h07ff, 16'hffff);
		wr(`SPO_A_MODE, 16'h0000);
		wr(`SPO_A_DECEL, 16'h0000);
		rd(`SPO_A_DECEL, 16'h0001, 16'hffff);
		wr(`SPO_A_DECEL, 16'hffff);
		rd(`SPO_A_DECEL, 16'h03e8, 16'hffff);
		wr(`SPO_A_DECEL, 16'h0001);
		wr(`SPO_A_DETECT, 16'h0002);
		wr(`SPO_A_HOLD, 16'h0001);
		wr(`SPO_A_IEN, 16'h0003);
		// commands while the function is switched off
		@(posedge core_clk);
		zero_cmd <= 1;
		run_cmd <= 1;
		repeat (8) @(posedge core_clk);
		#1 chk("idle", 0, pos_mode | (speed_ref != 0));
		@(posedge core_clk);
		zero_cmd <= 0;
		run_cmd <= 0;
		for (int i = 0; i < 4; i++)
		begin
			run(modes[i], fires[i]);
			if (i == 0)
			begin
				chk("zero_pos", 1, 16'(zp_n));
				rd(`SPO_A_ISTAT, 16'h0003, 16'h0003);
				irqchk(1);
				wr(`SPO_A_IEN, 16'h0000);
				irqchk(0);
				wr(`SPO_A_IEN, 16'h0003);
				irqchk(1);
				wr(`SPO_A_ICLR, 16'h0007);
				irqchk(0);
			end
		end
		chk("zero_pos", 1, 16'(zp_n));
		results;
	end
endmodule
